// >>> legacy_rx_frame_pkg.sv
// constants, types and register map for the legacy receive frame emitter
`default_nettype none
package legacy_rx_frame_pkg;
    // -------------------------------------------------------------------
    // frame bytes
    // -------------------------------------------------------------------
    localparam logic [7:0]  START_DELIM    = 8'h7E;
    localparam logic [7:0]  TYPE_RX16      = 8'h81;
    localparam logic [7:0]  TYPE_IO64      = 8'h82;
    localparam logic [7:0]  CSUM_BASE      = 8'hFF;
    localparam logic [7:0]  API_SEL_LEGACY = 8'h02;
    localparam logic [15:0] LONG_ADDR_MARK = 16'hFFFE;
    // -------------------------------------------------------------------
    // byte offsets and field positions
    // -------------------------------------------------------------------
    localparam int OFS_LEN_HI   = 1;
    localparam int OFS_LEN_LO   = 2;
    localparam int OFS_TYPE     = 3;
    localparam int RX16_SRC     = 4;
    localparam int RX16_RSSI    = 6;
    localparam int RX16_OPT     = 7;
    localparam int RX16_DATA    = 8;
    localparam int RX16_HDR_LEN = 5;
    localparam int IO64_SRC     = 4;
    localparam int IO64_RSSI    = 12;
    localparam int IO64_OPT     = 13;
    localparam int IO64_CNT     = 14;
    localparam int IO64_MASK    = 15;
    localparam int IO64_DIG     = 17;
    localparam int IO64_ANA     = 19;
    localparam int IO64_HDR_LEN = 14;
    localparam int OPT_BCAST    = 1;
    localparam int OPT_ALLNET   = 2;
    localparam int DIG_LINES    = 9;
    localparam int ANA_LSB      = 9;
    localparam int ANA_CH       = 4;
    localparam int BUF_BYTES    = 27;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [3:0]  CTRL_ADDR      = 4'h0;
    localparam logic [3:0]  OWN_ADDR_ADDR  = 4'h4;
    localparam logic [3:0]  STATUS_ADDR    = 4'h8;
    localparam logic [7:0]  API_SEL_RST    = 8'h00;
    localparam logic        API_MODE_RST   = 1'b0;
    localparam logic [15:0] OWN_ADDR_RST   = 16'h0000;
    localparam int          CTRL_MODE_BIT  = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef struct packed {
        logic                          is_sample;
        logic [63:0]                   src_addr;
        logic [7:0]                    rssi_dbm;
        logic                          bcast;
        logic                          bcast_all;
        logic [7:0]                    sample_count;
        logic [15:0]                   chan_mask;
        logic [15:0]                   digital;
        logic [ANA_CH-1:0][15:0]       analog;
        logic [7:0]                    pl_len;
    } frame_req_s;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR  = 4'b0010,
        ST_PAY  = 4'b0100,
        ST_CSUM = 4'b1000
    } emit_state_e;
endpackage
`default_nettype wire

// >>> legacy_rx_frame_emitter.sv
// legacy receive frame emitter: short-address packet and long-address sample frames
// Operation
// RULE_01: frame opens with start byte, then 16-bit length of bytes before checksum.
// RULE_02: last byte is 0xFF minus low byte of sum from offset 3; host checks.
// RULE_03: output select 2 and own address below 0xFFFE: packet frame type 0x81.
// RULE_04: packet frame: type at 3, 16-bit source at 4, RSSI 6, options 7.
// RULE_05: RSSI byte carries unsigned magnitude of the signal level in dBm.
// RULE_06: option bit 0 reserved, bit 1 broadcast, bit 2 all-network broadcast.
// RULE_07: packet frame carries received payload from offset 8 up to checksum.
// RULE_08: output select 2 and own address 0xFFFE: sample frame type 0x82.
// RULE_09: sample frames go out only in framed API mode, else suppressed.
// RULE_10: sample frame: 64-bit source at 4, RSSI 12, options 13, count 14.
// RULE_11: byte at offset 14 gives the number of sample sets.
// RULE_12: 16-bit mask at 15: digital bits 0-8, analog 9-12, 13-15 unused.
// RULE_13: digital word at 17 only if digital mask nonzero; unsampled lines zero.
// RULE_14: one 16-bit word per enabled analog channel, channel 0 upward, from 19.
// RULE_15: without digital word, analog words follow mask; length and checksum adapt.
`timescale 1ns/100ps
`default_nettype none
module legacy_rx_frame_emitter
    import legacy_rx_frame_pkg::*;
#(
    parameter int AXI_AW = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire frame_req_s        req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [7:0]        pl_data,
    input  wire logic              pl_valid,
    output logic                   pl_ready,
    output logic [7:0]             tx_data,
    output logic                   tx_valid,
    input  wire logic              tx_ready
);
    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    logic                          aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff, wr_go;
    logic                          api_mode_ff, sample_ff, tx_valid_ff, req_fire, short_ok;
    logic                          samp_ok, go, out_free, load, last_byte;
    logic [AXI_AW-1:0]             awaddr_ff;
    logic [3:0]                    wstrb_ff;
    logic [1:0]                    bresp_ff, rresp_ff;
    logic [31:0]                   wdata_ff, rdata_ff;
    logic [7:0]                    api_sel_ff, drop_cnt_ff, sum_ff, tx_data_ff, nxt_byte;
    logic [7:0]                    rssi_b, opt_b;
    logic [15:0]                   own_addr_ff, sent_cnt_ff, len_ff, idx_ff, nxt_len, dig_w;
    emit_state_e                   st_ff;
    logic [BUF_BYTES-1:0][7:0]     buf_ff, nxt_buf;
    logic [4:0]                    pos;
    // -------------------------------------------------------------------
    // axi4-lite write channel
    // -------------------------------------------------------------------
    assign awready = !aw_hold_ff && !bvalid_ff;
    assign wready  = !w_hold_ff && !bvalid_ff;
    assign wr_go   = aw_hold_ff && w_hold_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            if (awaddr_ff[3:2] == CTRL_ADDR[3:2] || awaddr_ff[3:2] == OWN_ADDR_ADDR[3:2]
                || awaddr_ff[3:2] == STATUS_ADDR[3:2]) begin
                bresp_ff <= RESP_OKAY;
            end else begin
                bresp_ff <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    // status is read-only; writes to it are acknowledged and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            api_sel_ff  <= API_SEL_RST;
            api_mode_ff <= API_MODE_RST;
            own_addr_ff <= OWN_ADDR_RST;
        end else if (wr_go) begin
            if (awaddr_ff[3:2] == CTRL_ADDR[3:2]) begin
                if (wstrb_ff[0]) api_sel_ff <= wdata_ff[7:0];
                if (wstrb_ff[1]) api_mode_ff <= wdata_ff[CTRL_MODE_BIT];
            end else if (awaddr_ff[3:2] == OWN_ADDR_ADDR[3:2]) begin
                if (wstrb_ff[0]) own_addr_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) own_addr_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end
    // -------------------------------------------------------------------
    // axi4-lite read channel
    // -------------------------------------------------------------------
    assign arready = !rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= RESP_OKAY;
            if (araddr[3:2] == CTRL_ADDR[3:2]) begin
                rdata_ff <= {23'h0, api_mode_ff, api_sel_ff};
            end else if (araddr[3:2] == OWN_ADDR_ADDR[3:2]) begin
                rdata_ff <= {16'h0, own_addr_ff};
            end else if (araddr[3:2] == STATUS_ADDR[3:2]) begin
                rdata_ff <= {sent_cnt_ff, drop_cnt_ff, 7'h0, (st_ff != ST_IDLE)};
            end else begin
                rdata_ff <= '0;
                rresp_ff <= RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    // -------------------------------------------------------------------
    // request qualification
    // -------------------------------------------------------------------
    assign req_ready = (st_ff == ST_IDLE);
    assign req_fire  = req_valid && req_ready;
    assign short_ok  = !req.is_sample && api_sel_ff == API_SEL_LEGACY
                       && own_addr_ff < LONG_ADDR_MARK; // [RULE_03]
    assign samp_ok   = req.is_sample && api_sel_ff == API_SEL_LEGACY
                       && own_addr_ff == LONG_ADDR_MARK
                       && api_mode_ff; // [RULE_08] [RULE_09]
    assign go        = short_ok || samp_ok;
    // -------------------------------------------------------------------
    // header image built at acceptance
    // -------------------------------------------------------------------
    assign rssi_b = 8'(-req.rssi_dbm); // [RULE_05]
    assign opt_b  = {5'h0, req.bcast_all, req.bcast, 1'b0}; // [RULE_06]
    assign dig_w  = req.digital & {7'h0, req.chan_mask[DIG_LINES-1:0]}; // [RULE_13]
    always_comb begin
        nxt_buf = '0;
        pos     = 5'(IO64_DIG);
        nxt_buf[0] = START_DELIM; // [RULE_01]
        if (req.is_sample) begin
            nxt_buf[OFS_TYPE] = TYPE_IO64; // [RULE_08]
            for (int i = 0; i < 8; i++) begin
                nxt_buf[IO64_SRC+i] = req.src_addr[63-8*i -: 8]; // [RULE_10]
            end
            nxt_buf[IO64_RSSI] = rssi_b;
            nxt_buf[IO64_OPT]  = opt_b;
            nxt_buf[IO64_CNT]  = req.sample_count; // [RULE_11]
            nxt_buf[IO64_MASK]   = {3'h0, req.chan_mask[12:8]}; // [RULE_12]
            nxt_buf[IO64_MASK+1] = req.chan_mask[7:0];
            if (|req.chan_mask[DIG_LINES-1:0]) begin
                nxt_buf[pos]        = dig_w[15:8]; // [RULE_13]
                nxt_buf[pos+5'd1]   = dig_w[7:0];
                pos = pos + 5'd2; // [RULE_15]
            end
            for (int c = 0; c < ANA_CH; c++) begin
                if (req.chan_mask[ANA_LSB+c]) begin
                    nxt_buf[pos]      = req.analog[c][15:8]; // [RULE_14]
                    nxt_buf[pos+5'd1] = req.analog[c][7:0];
                    pos = pos + 5'd2;
                end
            end
            nxt_len = 16'(pos) - 16'(OFS_TYPE); // [RULE_15]
        end else begin
            nxt_buf[OFS_TYPE]   = TYPE_RX16; // [RULE_04]
            nxt_buf[RX16_SRC]   = req.src_addr[15:8];
            nxt_buf[RX16_SRC+1] = req.src_addr[7:0];
            nxt_buf[RX16_RSSI]  = rssi_b;
            nxt_buf[RX16_OPT]   = opt_b;
            nxt_len = 16'(RX16_HDR_LEN) + 16'(req.pl_len); // [RULE_07]
        end
        nxt_buf[OFS_LEN_HI] = nxt_len[15:8]; // [RULE_01]
        nxt_buf[OFS_LEN_LO] = nxt_len[7:0];
    end
    // -------------------------------------------------------------------
    // byte emission
    // -------------------------------------------------------------------
    // output register only advances when it is empty or the host side takes its byte
    assign out_free  = !tx_valid_ff || tx_ready;
    assign pl_ready  = (st_ff == ST_PAY) && out_free; // [RULE_07]
    assign load      = out_free && (st_ff == ST_HDR || st_ff == ST_CSUM
                       || (st_ff == ST_PAY && pl_valid));
    assign last_byte = (idx_ff == len_ff + 16'd2);
    assign tx_data   = tx_data_ff;
    assign tx_valid  = tx_valid_ff;
    always_comb begin
        case (st_ff)
            ST_HDR:  nxt_byte = buf_ff[idx_ff[4:0]];
            ST_PAY:  nxt_byte = pl_data;
            ST_CSUM: nxt_byte = CSUM_BASE - sum_ff; // [RULE_02]
            default: nxt_byte = 8'h00;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff     <= ST_IDLE;
            buf_ff    <= '0;
            len_ff    <= '0;
            idx_ff    <= '0;
            sample_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (req_fire && go) begin
                        buf_ff    <= nxt_buf;
                        len_ff    <= nxt_len;
                        idx_ff    <= '0;
                        sample_ff <= req.is_sample;
                        st_ff     <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (load) begin
                        idx_ff <= idx_ff + 16'd1;
                        if (last_byte) begin
                            st_ff <= ST_CSUM;
                        end else if (!sample_ff && idx_ff == 16'(RX16_DATA-1)) begin
                            st_ff <= ST_PAY; // [RULE_07]
                        end
                    end
                end
                ST_PAY: begin
                    if (load) begin
                        idx_ff <= idx_ff + 16'd1;
                        if (last_byte) st_ff <= ST_CSUM;
                    end
                end
                ST_CSUM: begin
                    if (load) st_ff <= ST_IDLE;
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end
    // checksum runs over everything after the length field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sum_ff <= '0;
        end else if (st_ff == ST_IDLE) begin
            sum_ff <= '0;
        end else if (load && st_ff != ST_CSUM && idx_ff >= 16'(OFS_TYPE)) begin
            sum_ff <= sum_ff + nxt_byte; // [RULE_02]
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= '0;
        end else if (out_free) begin
            tx_valid_ff <= load;
            if (load) tx_data_ff <= nxt_byte;
        end
    end
    // counters wrap; software takes differences
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drop_cnt_ff <= '0;
            sent_cnt_ff <= '0;
        end else begin
            if (req_fire && !go) drop_cnt_ff <= drop_cnt_ff + 8'd1; // [RULE_09]
            if (st_ff == ST_CSUM && load) sent_cnt_ff <= sent_cnt_ff + 16'd1;
        end
    end
    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_start_byte;
        load && st_ff == ST_HDR && idx_ff == 16'd0 |=> tx_data_ff == START_DELIM;
    endproperty
    a_start_byte: assert property (p_start_byte) // [RULE_01]
        else $error("first frame byte is not the start delimiter");
    property p_checksum;
        load && st_ff == ST_CSUM |=> tx_valid_ff && 8'(tx_data_ff + sum_ff) == CSUM_BASE;
    endproperty
    a_checksum: assert property (p_checksum) // [RULE_02]
        else $error("checksum byte does not complete the sum");
    property p_short_type;
        req_fire && !req.is_sample && short_ok
            |=> st_ff == ST_HDR && buf_ff[OFS_TYPE] == TYPE_RX16;
    endproperty
    a_short_type: assert property (p_short_type) // [RULE_03]
        else $error("short address packet not framed as 0x81");
    property p_long_type;
        req_fire && samp_ok |=> st_ff == ST_HDR && buf_ff[OFS_TYPE] == TYPE_IO64;
    endproperty
    a_long_type: assert property (p_long_type) // [RULE_08]
        else $error("sample frame not framed as 0x82");
    property p_suppress;
        req_fire && req.is_sample && !api_mode_ff
            |=> st_ff == ST_IDLE && drop_cnt_ff == $past(drop_cnt_ff) + 8'd1;
    endproperty
    a_suppress: assert property (p_suppress) // [RULE_09]
        else $error("sample frame emitted outside api mode");
    property p_rssi;
        req_fire && go && req.is_sample |=> buf_ff[IO64_RSSI] == 8'(-$past(req.rssi_dbm));
    endproperty
    a_rssi: assert property (p_rssi) // [RULE_05]
        else $error("rssi byte is not the level magnitude");
    property p_opt_reserved;
        st_ff != ST_IDLE && !sample_ff |-> buf_ff[RX16_OPT][0] == 1'b0
            && buf_ff[RX16_OPT][7:3] == 5'h0;
    endproperty
    a_opt_reserved: assert property (p_opt_reserved) // [RULE_06]
        else $error("reserved option bits set");
    property p_mask_unused;
        st_ff != ST_IDLE && sample_ff |-> buf_ff[IO64_MASK][7:5] == 3'h0;
    endproperty
    a_mask_unused: assert property (p_mask_unused) // [RULE_12]
        else $error("unused mask bits set");
    property p_sample_len;
        req_fire && samp_ok |=> len_ff == 16'(IO64_HDR_LEN)
            + ((|$past(req.chan_mask[8:0])) ? 16'd2 : 16'd0)
            + 16'd2 * 16'($countones($past(req.chan_mask[12:9])));
    endproperty
    a_sample_len: assert property (p_sample_len) // [RULE_15]
        else $error("sample frame length wrong");
    property p_pay_window;
        pl_ready |-> st_ff == ST_PAY && idx_ff >= 16'(RX16_DATA) && !sample_ff;
    endproperty
    a_pay_window: assert property (p_pay_window) // [RULE_07]
        else $error("payload taken outside its window");
endmodule // legacy_rx_frame_emitter
`default_nettype wire

// >>> host_serial_model.sv
// host side model: collects frame bytes, stalling at random
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var logic        tx_ready
);
    logic [7:0]  got[$];
    logic [15:0] seed_ff;
    // stalls make the emitter hold the byte it is offering until tx_ready returns
    always @(posedge aclk) begin
        if (!aresetn) begin
            seed_ff  <= 16'h4A05;
            tx_ready <= 1'b0;
        end else begin
            seed_ff  <= {seed_ff[14:0], seed_ff[15] ^ seed_ff[13] ^ seed_ff[12] ^ seed_ff[10]};
            tx_ready <= seed_ff[3] | seed_ff[7];
            if (tx_valid && tx_ready) got.push_back(tx_data);
        end
    end
endmodule // host_serial_model
`default_nettype wire

// >>> legacy_rx_frame_emitter_bench.sv
// testbench of the legacy receive frame emitter
`timescale 1ns/100ps
`default_nettype none
module legacy_rx_frame_emitter_bench;
    import legacy_rx_frame_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, req_valid, req_ready, pl_valid, pl_ready, tx_valid, tx_ready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, lf;
    logic [1:0] bresp, rresp;
    logic [7:0] pl_data, tx_data, exp[$], pay[$];
    frame_req_s req, r;
    int err_count, cmp_count, n_emit, n_drop;
    legacy_rx_frame_emitter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .pl_data(pl_data), .pl_valid(pl_valid), .pl_ready(pl_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    host_serial_model host (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // payload source: front of pay is offered until taken
    always @(posedge aclk) begin
        if (pl_valid && pl_ready) void'(pay.pop_front());
        pl_valid <= pay.size() > 0;
        pl_data <= (pay.size() > 0) ? pay[0] : 8'h00;
    end
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic frame_req_s rnd_req(input logic smp);
        logic [223:0] t;
        frame_req_s q;
        t = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        q = t[$bits(frame_req_s)-1:0];
        q.is_sample = smp;
        q.pl_len = smp ? 8'h00 : {5'h00, q.pl_len[2:0]};
        return q;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, RESP_OKAY);
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic run(input frame_req_s q, input logic emit);
        logic [7:0] b[$];
        logic [7:0] s;
        int i;
        for (i = 0; i < q.pl_len; i++) pay.push_back(8'(rnd()));
        b.push_back(q.is_sample ? TYPE_IO64 : TYPE_RX16);
        for (i = q.is_sample ? 7 : 1; i >= 0; i--) b.push_back(q.src_addr[i*8+:8]);
        b.push_back(8'h00 - q.rssi_dbm);
        b.push_back({5'h00, q.bcast_all, q.bcast, 1'b0});
        if (q.is_sample) begin
            b.push_back(q.sample_count);
            b.push_back({3'h0, q.chan_mask[12:8]});
            b.push_back(q.chan_mask[7:0]);
            if (q.chan_mask[8:0] != 9'h000) begin
                b.push_back({7'h00, q.digital[8] & q.chan_mask[8]});
                b.push_back(q.digital[7:0] & q.chan_mask[7:0]);
            end
            for (i = 0; i < ANA_CH; i++)
                if (q.chan_mask[ANA_LSB+i]) begin
                    b.push_back(q.analog[i][15:8]);
                    b.push_back(q.analog[i][7:0]);
                end
        end else foreach (pay[i]) b.push_back(pay[i]);
        s = 8'h00;
        foreach (b[i]) s += b[i];
        exp = {};
        if (emit) exp = {START_DELIM, 8'h00, 8'(b.size()), b, CSUM_BASE - s};
        n_emit += emit;
        n_drop += !emit;
        req <= q;
        req_valid <= 1'b1;
        do @(posedge aclk); while (!req_ready);
        req_valid <= 1'b0;
        @(posedge aclk);
        while (!req_ready || tx_valid) @(posedge aclk);
        chk(host.got.size(), exp.size());
        if (host.got.size() == exp.size())
            foreach (exp[i]) chk(host.got[i], exp[i]);
        s = 8'h00;
        foreach (host.got[i]) if (i >= OFS_TYPE) s += host.got[i];
        if (emit) chk(s, CSUM_BASE);
        host.got = {};
        pay = {};
    endtask
    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        err_count++;
        stop_test();
    end
    initial begin
        aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; req = '0; req_valid = 0;
        lf = 32'h4A05; err_count = 0; cmp_count = 0; n_emit = 0; n_drop = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(4'hC);
        chk(rresp, RESP_SLVERR);
        wr(CTRL_ADDR, 32'h0000_0102);
        wr(OWN_ADDR_ADDR, 32'h0000_1234);
        r = '0;
        r.src_addr = 64'h1234;
        r.rssi_dbm = 8'hD8;
        r.bcast = 1'b1;
        r.bcast_all = 1'b1;
        r.pl_len = 8'h06;
        run(r, 1'b1);
        repeat (5) run(rnd_req(1'b0), 1'b1);
        run(rnd_req(1'b1), 1'b0);
        wr(OWN_ADDR_ADDR, {16'h0000, LONG_ADDR_MARK});
        run(rnd_req(1'b0), 1'b0);
        run(rnd_req(1'b1), 1'b1);
        repeat (4) run(rnd_req(1'b1), 1'b1);
        r = rnd_req(1'b1);
        r.chan_mask &= 16'hFE00;
        run(r, 1'b1);
        wr(CTRL_ADDR, 32'h0000_0002);
        run(rnd_req(1'b1), 1'b0);
        rd(CTRL_ADDR);
        chk(rdata, 32'h0000_0002);
        rd(OWN_ADDR_ADDR);
        chk(rdata, {16'h0000, LONG_ADDR_MARK});
        rd(STATUS_ADDR);
        chk(rdata, {16'(n_emit), 8'(n_drop), 8'h00});
        stop_test();
    end
endmodule // legacy_rx_frame_emitter_bench
`default_nettype wire
